// [core/acq_pkg.sv]
// constants, types and register map of the acquisition trigger controller
// assumes a single 200 MHz system clock and an axi4-lite register master
//
// Operation
// - four trigger modes plus pause function
// - start mode drops clocks before trigger
// - delay-to-start waits 24-bit count after trigger
// - delay-to-stop acquires from first clock
// - delay-to-stop runs programmed clocks after trigger
// - stop mode ends at trigger, no extra
// - one 24-bit counter serves both delay modes
// - per-channel gain, half gain only written while bipolar
// - control enables conversion, divider register sets interval
// - trigger edge polarity selectable by software
// - each gated clock edge starts one conversion
// - internal clock from 32-bit divider
package acq_pkg;

  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned DELAY_W     = 24;
  localparam int unsigned DIV_W       = 32;
  localparam int unsigned NUM_CH      = 8;
  localparam int unsigned GAIN_W      = 3;
  localparam int unsigned TIMEBASE_HZ = 100_000_000;
  localparam int unsigned SYS_HZ      = 200_000_000;
  // system cycles per time-base tick
  localparam int unsigned TB_DIV      = SYS_HZ / TIMEBASE_HZ;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] DELAY_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] DIV_OFS    = 8'h08;
  localparam logic [ADDR_W-1:0] GAIN_OFS   = 8'h0C;
  localparam logic [ADDR_W-1:0] STAT_OFS   = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_OFS    = 8'h14;
  localparam logic [ADDR_W-1:0] MASK_OFS   = 8'h18;
  localparam logic [ADDR_W-1:0] COUNT_OFS  = 8'h1C;

  // control register fields
  localparam int unsigned CTRL_RUN     = 0;
  localparam int unsigned CTRL_PAUSE   = 1;
  localparam int unsigned CTRL_MODE_LO = 2;
  localparam int unsigned CTRL_FALL    = 4;
  localparam int unsigned CTRL_SRC     = 5;
  localparam int unsigned CTRL_EXTCLK  = 6;
  localparam int unsigned CTRL_BIPOLAR = 7;

  // irq status bits
  localparam int unsigned IRQ_TRIG  = 0;
  localparam int unsigned IRQ_DONE  = 1;
  localparam int unsigned IRQ_GAIN  = 2;
  localparam int unsigned IRQ_W     = 3;

  // gain codes
  localparam logic [GAIN_W-1:0] GAIN_HALF = 3'h0;
  localparam logic [GAIN_W-1:0] GAIN_X1   = 3'h1;
  localparam logic [GAIN_W-1:0] GAIN_X8   = 3'h4;
  // gain write word: channel number sits above the code
  localparam int unsigned       GAIN_CH_LO = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_START, MODE_DLY_START, MODE_DLY_STOP, MODE_STOP
  } trig_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ARMED, ST_DELAY, ST_ACQ, ST_POST, ST_DONE
  } acq_state_t;

  // first member is the top bit, so run lands in bit 0
  typedef struct packed {
    logic              bipolar;
    logic              ext_clk;
    logic              src_analog;
    logic              falling;
    trig_mode_t        mode;
    logic              pause;
    logic              run;
  } ctrl_t;

endpackage : acq_pkg

// [core/gain_store.sv]
// per-channel gain memory with registered read port
// assumes writes come from the register slave in the same clock domain
`timescale 1ns/1ps
`default_nettype none
module gain_store
  import acq_pkg::*;
#(
  parameter int unsigned CH = NUM_CH
)
(
  input  wire logic               clk_sys, // system clock
  input  wire logic               rstn,    // async reset, low
  input  wire logic               we,      // write strobe
  input  wire logic [$clog2(CH)-1:0] waddr, // channel to write
  input  wire logic [GAIN_W-1:0]  wdata,   // gain code
  input  wire logic [$clog2(CH)-1:0] raddr, // channel to read
  output logic      [GAIN_W-1:0]  rdata,   // registered read
  output logic      [CH*GAIN_W-1:0] all_q  // every channel gain
);
  logic [GAIN_W-1:0] mem_q [CH];
  logic [GAIN_W-1:0] mem_d [CH];
  logic [GAIN_W-1:0] rdata_d;

  genvar g;
  generate
    for (g = 0; g < CH; g++)
    begin : g_ch
      assign mem_d[g] = (we && waddr == g) ? wdata : mem_q[g];
      assign all_q[g*GAIN_W +: GAIN_W] = mem_q[g];
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn) mem_q[g] <= GAIN_X1;
        else       mem_q[g] <= mem_d[g];
      end
    end
  endgenerate

  always_comb
  begin
    rdata_d = mem_q[raddr];
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn) rdata <= '0;
    else       rdata <= rdata_d;
  end
endmodule : gain_store
`default_nettype wire

// [core/acq_trigger_ctrl.sv]
// trigger and acquisition sequencing with axi4-lite registers
// assumes pin inputs are asynchronous; analog comparator output arrives
// as a digital level
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module acq_trigger_ctrl
  import acq_pkg::*;
(
  input  wire logic              clk_sys,       // 200 MHz clock
  input  wire logic              rstn,          // async reset, low
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write address
  input  wire logic              s_axi_awvalid, // write address valid
  output logic                   s_axi_awready, // write address ready
  input  wire logic [DATA_W-1:0] s_axi_wdata,   // write data
  input  wire logic [3:0]        s_axi_wstrb,   // byte enables
  input  wire logic              s_axi_wvalid,  // write data valid
  output logic                   s_axi_wready,  // write data ready
  output logic [1:0]             s_axi_bresp,   // write response
  output logic                   s_axi_bvalid,  // write response valid
  input  wire logic              s_axi_bready,  // response ready
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read address
  input  wire logic              s_axi_arvalid, // read address valid
  output logic                   s_axi_arready, // read address ready
  output logic [DATA_W-1:0]      s_axi_rdata,   // read data
  output logic [1:0]             s_axi_rresp,   // read response
  output logic                   s_axi_rvalid,  // read data valid
  input  wire logic              s_axi_rready,  // read data ready
  input  wire logic              dig_trig_pin,  // ttl trigger pin
  input  wire logic              ana_trig_pin,  // threshold comparator
  input  wire logic              ext_conv_pin,  // external conversion clock
  output logic                   conv_start,    // one conversion pulse
  output logic                   acq_active,    // acquisition running
  output logic [NUM_CH*GAIN_W-1:0] gain_sel,    // programmable_gain_amp
  output logic                   irq            // level interrupt
);
  // synchronisers: stage one read only by stage two
  logic [2:0] sync1_q, sync2_q, prev_q;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end
    else
    begin
      sync1_q <= {ext_conv_pin, ana_trig_pin, dig_trig_pin};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  // registers
  ctrl_t              ctrl_q, ctrl_d;
  logic [DELAY_W-1:0] delay_q, delay_d;
  logic [DIV_W-1:0]   div_q, div_d;
  logic [IRQ_W-1:0]   stat_q, stat_d, mask_q, mask_d;
  logic               gain_we;
  logic [GAIN_W-1:0]  gain_rd;

  // axi slave state
  logic              aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [DATA_W-1:0] wdata_q, wdata_d;
  logic              bvalid_d, arready_d, rvalid_d;
  logic [1:0]        bresp_d, rresp_d;
  logic [DATA_W-1:0] rdata_d;
  logic              rd_pend_q, rd_pend_d;
  logic [ADDR_W-1:0] araddr_q, araddr_d;
  logic              do_write;

  // sequencer state
  acq_state_t         st_q, st_d;
  logic [DELAY_W-1:0] cnt_q, cnt_d;
  logic [DIV_W-1:0]   divcnt_q, divcnt_d;
  logic [$clog2(TB_DIV+1)-1:0] tb_q, tb_d;
  logic               conv_d, active_d, irq_d, run_q;
  logic               trig_ev, clk_ev, int_tick, trig_lvl, trig_prev;
  logic               ev_trig, ev_done, ev_gain;

  gain_store #(.CH(NUM_CH)) u_gain (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .we      (gain_we),
    .waddr   (wdata_q[GAIN_CH_LO +: $clog2(NUM_CH)]),
    .wdata   (wdata_q[GAIN_W-1:0]),
    .raddr   (wdata_q[GAIN_CH_LO +: $clog2(NUM_CH)]),
    .rdata   (gain_rd),
    .all_q   (gain_sel)
  );

  assign do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;

  always_comb
  begin
    aw_hold_d = aw_hold_q;
    w_hold_d  = w_hold_q;
    awaddr_d  = awaddr_q;
    wdata_d   = wdata_q;
    bvalid_d  = s_axi_bvalid;
    bresp_d   = s_axi_bresp;
    ctrl_d    = ctrl_q;
    delay_d   = delay_q;
    div_d     = div_q;
    mask_d    = mask_q;
    gain_we   = 1'b0;
    ev_gain   = 1'b0;
    if (s_axi_awvalid && s_axi_awready)
    begin
      aw_hold_d = 1'b1;
      awaddr_d  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      w_hold_d = 1'b1;
      wdata_d  = s_axi_wdata;
    end
    if (s_axi_bvalid && s_axi_bready)
      bvalid_d = 1'b0;
    if (do_write)
    begin
      aw_hold_d = 1'b0;
      w_hold_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = RESP_OKAY;
      case (awaddr_q)
        CTRL_OFS:  ctrl_d  = ctrl_t'(wdata_q[$bits(ctrl_t)-1:0]);
        DELAY_OFS: delay_d = wdata_q[DELAY_W-1:0];
        DIV_OFS:   div_d   = wdata_q;
        MASK_OFS:  mask_d  = wdata_q[IRQ_W-1:0];
        GAIN_OFS:
        begin
          // half gain refused unless the range is bipolar
          if (wdata_q[GAIN_W-1:0] > GAIN_X8 ||
              (wdata_q[GAIN_W-1:0] == GAIN_HALF && !ctrl_q.bipolar))
          begin
            bresp_d = RESP_SLVERR;
            ev_gain = 1'b1;
          end
          else
            gain_we = 1'b1;
        end
        STAT_OFS, IRQ_OFS, COUNT_OFS: ;
        default:   bresp_d = RESP_SLVERR;
      endcase
    end
  end

  always_comb
  begin
    rd_pend_d = rd_pend_q;
    araddr_d  = araddr_q;
    arready_d = 1'b0;
    rvalid_d  = s_axi_rvalid;
    rdata_d   = s_axi_rdata;
    rresp_d   = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready)
      rvalid_d = 1'b0;
    if (!rd_pend_q && !s_axi_rvalid && s_axi_arvalid && !s_axi_arready)
      arready_d = 1'b1;
    if (s_axi_arvalid && s_axi_arready)
    begin
      rd_pend_d = 1'b1;
      araddr_d  = s_axi_araddr;
    end
    if (rd_pend_q)
    begin
      rd_pend_d = 1'b0;
      rvalid_d  = 1'b1;
      rresp_d   = RESP_OKAY;
      rdata_d   = '0;
      case (araddr_q)
        CTRL_OFS:  rdata_d[$bits(ctrl_t)-1:0] = ctrl_q;
        DELAY_OFS: rdata_d[DELAY_W-1:0] = delay_q;
        DIV_OFS:   rdata_d = div_q;
        GAIN_OFS:  rdata_d[GAIN_W-1:0] = gain_rd;
        STAT_OFS:  rdata_d[$bits(acq_state_t):0] = {acq_active, st_q};
        IRQ_OFS:   rdata_d[IRQ_W-1:0] = stat_q;
        MASK_OFS:  rdata_d[IRQ_W-1:0] = mask_q;
        COUNT_OFS: rdata_d[DELAY_W-1:0] = cnt_q;
        default:   rresp_d = RESP_SLVERR;
      endcase
    end
  end

  // trigger source and polarity
  always_comb
  begin
    trig_lvl  = ctrl_q.src_analog ? sync2_q[1] : sync2_q[0];
    trig_prev = ctrl_q.src_analog ? prev_q[1] : prev_q[0];
    trig_ev   = ctrl_q.falling ? (trig_prev && !trig_lvl)
                               : (!trig_prev && trig_lvl);
  end

  // 100 MHz time base then programmable divider
  always_comb
  begin
    int_tick = 1'b0;
    divcnt_d = divcnt_q;
    tb_d     = tb_q + 1'b1;
    if (tb_q == $bits(tb_q)'(TB_DIV - 1))
    begin
      tb_d = '0;
      if (divcnt_q >= div_q)
      begin
        divcnt_d = '0;
        int_tick = ctrl_q.run;
      end
      else
        divcnt_d = divcnt_q + 1'b1;
    end
    if (!ctrl_q.run)
      divcnt_d = '0;
    clk_ev = ctrl_q.ext_clk ? (sync2_q[2] && !prev_q[2]) : int_tick;
  end

  always_comb
  begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    conv_d   = 1'b0;
    ev_trig  = 1'b0;
    ev_done  = 1'b0;
    if (!ctrl_q.run)
      st_d = ST_IDLE;
    else if (!ctrl_q.pause)
    begin
      case (st_q)
        ST_IDLE:
          if (!run_q)
            st_d = (ctrl_q.mode == MODE_START ||
                    ctrl_q.mode == MODE_DLY_START) ? ST_ARMED : ST_ACQ;
        ST_ARMED:
          if (trig_ev)
          begin
            ev_trig = 1'b1;
            cnt_d   = delay_q;
            st_d    = (ctrl_q.mode == MODE_DLY_START && delay_q != '0)
                      ? ST_DELAY : ST_ACQ;
          end
        ST_DELAY:
          if (clk_ev)
          begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == DELAY_W'(1))
              st_d = ST_ACQ;
          end
        ST_ACQ:
        begin
          if (trig_ev && ctrl_q.mode == MODE_STOP)
          begin
            ev_trig = 1'b1;
            ev_done = 1'b1;
            st_d    = ST_DONE;
          end
          else
          begin
            if (clk_ev)
              conv_d = 1'b1;
            if (trig_ev && ctrl_q.mode == MODE_DLY_STOP)
            begin
              ev_trig = 1'b1;
              cnt_d   = delay_q;
              st_d    = (delay_q == '0) ? ST_DONE : ST_POST;
              ev_done = (delay_q == '0);
            end
          end
        end
        ST_POST:
          if (clk_ev)
          begin
            conv_d = 1'b1;
            cnt_d  = cnt_q - 1'b1;
            if (cnt_q == DELAY_W'(1))
            begin
              st_d    = ST_DONE;
              ev_done = 1'b1;
            end
          end
        ST_DONE: ;
        default: st_d = ST_IDLE;
      endcase
    end
    active_d = (st_d == ST_ACQ || st_d == ST_POST);
  end

  // sticky irq status: read clears, new event wins
  always_comb
  begin
    stat_d = stat_q;
    if (rd_pend_q && araddr_q == IRQ_OFS)
      stat_d = '0;
    if (ev_trig) stat_d[IRQ_TRIG] = 1'b1;
    if (ev_done) stat_d[IRQ_DONE] = 1'b1;
    if (ev_gain) stat_d[IRQ_GAIN] = 1'b1;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= '0;
      wdata_q       <= '0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      rd_pend_q     <= 1'b0;
      araddr_q      <= '0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
      ctrl_q        <= '0;
      delay_q       <= '0;
      div_q         <= '0;
      mask_q        <= '0;
      stat_q        <= '0;
      st_q          <= ST_IDLE;
      cnt_q         <= '0;
      divcnt_q      <= '0;
      tb_q          <= '0;
      run_q         <= 1'b0;
      conv_start    <= 1'b0;
      acq_active    <= 1'b0;
      irq           <= 1'b0;
    end
    else
    begin
      aw_hold_q     <= aw_hold_d;
      w_hold_q      <= w_hold_d;
      awaddr_q      <= awaddr_d;
      wdata_q       <= wdata_d;
      s_axi_bvalid  <= bvalid_d;
      s_axi_bresp   <= bresp_d;
      s_axi_awready <= !aw_hold_d && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_d && !s_axi_wready && s_axi_wvalid;
      rd_pend_q     <= rd_pend_d;
      araddr_q      <= araddr_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid  <= rvalid_d;
      s_axi_rdata   <= rdata_d;
      s_axi_rresp   <= rresp_d;
      ctrl_q        <= ctrl_d;
      delay_q       <= delay_d;
      div_q         <= div_d;
      mask_q        <= mask_d;
      stat_q        <= stat_d;
      st_q          <= st_d;
      cnt_q         <= cnt_d;
      divcnt_q      <= divcnt_d;
      tb_q          <= tb_d;
      run_q         <= (st_q != ST_IDLE);
      conv_start    <= conv_d;
      acq_active    <= active_d;
      irq           <= irq_d;
    end
  end
endmodule : acq_trigger_ctrl
`default_nettype wire

// [verification/acq_trigger_ctrl_props.sv]
// port-level checker for the acquisition trigger controller
// assumes it is bound to the top module; one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module acq_trigger_ctrl_props
  import acq_pkg::*;
(
  input wire logic                      clk_sys,       // system clock
  input wire logic                      rstn,          // reset, low
  input wire logic                      s_axi_awvalid, // aw valid
  input wire logic                      s_axi_awready, // aw ready
  input wire logic                      s_axi_bvalid,  // b valid
  input wire logic                      s_axi_bready,  // b ready
  input wire logic [1:0]                s_axi_bresp,   // b response
  input wire logic                      s_axi_arvalid, // ar valid
  input wire logic                      s_axi_arready, // ar ready
  input wire logic                      s_axi_rvalid,  // r valid
  input wire logic                      s_axi_rready,  // r ready
  input wire logic [DATA_W-1:0]         s_axi_rdata,   // read data
  input wire logic [1:0]                s_axi_rresp,   // read response
  input wire logic                      conv_start,    // conversion pulse
  input wire logic                      acq_active,    // acquiring
  input wire logic [NUM_CH*GAIN_W-1:0]  gain_sel       // channel gains
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  // a code above x8 can never be stored, refused or not
  logic gain_ok;
  always_comb
  begin
    gain_ok = 1'h1;
    for (int i = 0; i < NUM_CH; i++)
      if (gain_sel[i*GAIN_W +: GAIN_W] > GAIN_X8) gain_ok = 1'h0;
  end

  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_r_answer;
    ##2 s_axi_rvalid;
  endsequence

  AST_CONV_PULSE: assert property (conv_start |=> !conv_start)
    else $error("conversion pulse longer than one cycle");
  // the last conversion may land as the active flag drops
  AST_CONV_IN_ACQ: assert property (
    conv_start |-> acq_active || $past(acq_active))
    else $error("conversion outside acquisition");
  AST_GAIN_RANGE: assert property (gain_ok)
    else $error("gain field holds an illegal code");
  AST_READ_LAT: assert property (s_ar_take |-> s_r_answer)
    else $error("read data not two cycles after address");
  AST_WRITE_LAT: assert property (
    s_axi_awvalid && s_axi_awready |-> ##[1:4] s_axi_bvalid)
    else $error("write response missing");
  AST_BVALID_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_RVALID_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("read data dropped early");
  AST_AWREADY_PULSE: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("address ready longer than one cycle");
endmodule : acq_trigger_ctrl_props
`default_nettype wire

// [verification/ai_trigger_acquisition_control_tb_top.sv]
// self-checking bench for the acquisition trigger controller
// assumes full-word register writes and ext clock pulses 4 cycles high and 4 low
`timescale 1ns/1ps
`default_nettype none
module ai_trigger_acquisition_control_tb_top
  import acq_pkg::*;
;
  logic clk_sys = 1'h0, rstn = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic dig_trig_pin = 1'h0, ana_trig_pin = 1'h0, ext_conv_pin = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, conv_start, acq_active, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [NUM_CH*GAIN_W-1:0] gain_sel;
  int bad_count = 0, n_tests = 0, convs = 0, c0 = 0;

  acq_trigger_ctrl acq_trigger_ctrl_inst (
    .clk_sys       (clk_sys),
    .rstn          (rstn),
    .s_axi_awaddr  (s_axi_awaddr),
    .s_axi_awvalid (s_axi_awvalid),
    .s_axi_awready (s_axi_awready),
    .s_axi_wdata   (s_axi_wdata),
    .s_axi_wstrb   (s_axi_wstrb),
    .s_axi_wvalid  (s_axi_wvalid),
    .s_axi_wready  (s_axi_wready),
    .s_axi_bresp   (s_axi_bresp),
    .s_axi_bvalid  (s_axi_bvalid),
    .s_axi_bready  (s_axi_bready),
    .s_axi_araddr  (s_axi_araddr),
    .s_axi_arvalid (s_axi_arvalid),
    .s_axi_arready (s_axi_arready),
    .s_axi_rdata   (s_axi_rdata),
    .s_axi_rresp   (s_axi_rresp),
    .s_axi_rvalid  (s_axi_rvalid),
    .s_axi_rready  (s_axi_rready),
    .dig_trig_pin  (dig_trig_pin),
    .ana_trig_pin  (ana_trig_pin),
    .ext_conv_pin  (ext_conv_pin),
    .conv_start    (conv_start),
    .acq_active    (acq_active),
    .gain_sel      (gain_sel),
    .irq           (irq)
  );

  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (conv_start === 1'h1) convs++;

  task automatic end_sim();
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (s_axi_bvalid !== 1'h1 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
    if (n >= 40)
    begin
      bad_count++;
      end_sim();
    end
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (s_axi_rvalid !== 1'h1 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
    if (n >= 40)
    begin
      bad_count++;
      end_sim();
    end
    chk("rresp", 32'(s_axi_rresp), 32'(er));
    if (er == RESP_OKAY) chk("rdata", s_axi_rdata, ed);
  endtask : axr

  // pin held 4 cycles each way, well above the synchroniser delay
  task automatic pulses(input int k);
    repeat (k)
    begin
      ext_conv_pin <= 1'h1;
      repeat (4) @(posedge clk_sys);
      ext_conv_pin <= 1'h0;
      repeat (4) @(posedge clk_sys);
    end
    repeat (4) @(posedge clk_sys);
  endtask : pulses

  task automatic trig(input logic v);
    dig_trig_pin <= v;
    repeat (6) @(posedge clk_sys);
  endtask : trig

  task automatic cv(input int e);
    chk("conversions", 32'(convs - c0), 32'(e));
    c0 = convs;
  endtask : cv

  initial
  begin
    repeat (2) @(posedge clk_sys);
    rstn <= 1'h1;
    axr(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    chk("gain reset", 32'(gain_sel), 32'h0024_9249);
    axr(8'h20, 32'h0000_0000, RESP_SLVERR);
    axw(CTRL_OFS, 32'h0000_0080, RESP_OKAY);
    for (int c = 0; c < 5; c++)
    begin
      axw(GAIN_OFS, (32'(c) << 8) | 32'(c), RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      chk("gain", 32'(gain_sel[c*GAIN_W +: GAIN_W]), 32'(c));
    end
    axr(GAIN_OFS, 32'h0000_0004, RESP_OKAY);
    axw(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    axw(GAIN_OFS, 32'h0000_0500, RESP_SLVERR);
    axw(GAIN_OFS, 32'h0000_0505, RESP_SLVERR);
    repeat (2) @(posedge clk_sys);
    chk("gain kept", 32'(gain_sel[17:15]), 32'h0000_0001);
    chk("irq masked", 32'(irq), 32'h0000_0000);
    axw(MASK_OFS, 32'h0000_0004, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk("irq", 32'(irq), 32'h0000_0001);
    axr(IRQ_OFS, 32'h0000_0004, RESP_OKAY);
    repeat (2) @(posedge clk_sys);
    chk("irq cleared", 32'(irq), 32'h0000_0000);
    axw(MASK_OFS, 32'h0000_0000, RESP_OKAY);
    // start mode, then pause and resume
    axw(CTRL_OFS, 32'h0000_0041, RESP_OKAY);
    pulses(2);
    cv(0);
    trig(1'h1);
    pulses(3);
    cv(3);
    chk("active", 32'(acq_active), 32'h0000_0001);
    axr(STAT_OFS, 32'(ST_ACQ) | 32'h0000_0008, RESP_OKAY);
    axw(CTRL_OFS, 32'h0000_0043, RESP_OKAY);
    pulses(2);
    cv(0);
    axw(CTRL_OFS, 32'h0000_0041, RESP_OKAY);
    pulses(1);
    cv(1);
    axw(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    trig(1'h0);
    chk("idle", 32'(acq_active), 32'h0000_0000);
    // delay-to-start, paused in mid-delay
    axw(DELAY_OFS, 32'h0000_0003, RESP_OKAY);
    axw(CTRL_OFS, 32'h0000_0045, RESP_OKAY);
    trig(1'h1);
    pulses(1);
    axw(CTRL_OFS, 32'h0000_0047, RESP_OKAY);
    pulses(2);
    cv(0);
    axr(COUNT_OFS, 32'h0000_0002, RESP_OKAY);
    axw(CTRL_OFS, 32'h0000_0045, RESP_OKAY);
    pulses(4);
    cv(2);
    axw(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    trig(1'h0);
    // delay-to-stop
    axr(IRQ_OFS, 32'h0000_0001, RESP_OKAY);
    axw(MASK_OFS, 32'h0000_0003, RESP_OKAY);
    axw(DELAY_OFS, 32'h0000_0002, RESP_OKAY);
    axw(CTRL_OFS, 32'h0000_0049, RESP_OKAY);
    pulses(2);
    cv(2);
    trig(1'h1);
    pulses(4);
    cv(2);
    chk("stopped", 32'(acq_active), 32'h0000_0000);
    chk("irq done", 32'(irq), 32'h0000_0001);
    axr(IRQ_OFS, 32'h0000_0003, RESP_OKAY);
    axw(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    // stop mode on a falling trigger edge
    axw(CTRL_OFS, 32'h0000_005d, RESP_OKAY);
    pulses(2);
    cv(2);
    trig(1'h0);
    pulses(2);
    cv(0);
    chk("stopped", 32'(acq_active), 32'h0000_0000);
    axw(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    // start mode on the analog comparator level
    axw(CTRL_OFS, 32'h0000_0061, RESP_OKAY);
    pulses(1);
    cv(0);
    ana_trig_pin <= 1'h1;
    repeat (6) @(posedge clk_sys);
    pulses(2);
    cv(2);
    axw(CTRL_OFS, 32'h0000_0000, RESP_OKAY);
    // internal clock, 40 ns period is 8 system cycles
    axw(DIV_OFS, 32'h0000_0003, RESP_OKAY);
    axw(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    trig(1'h1);
    c0 = convs;
    repeat (160) @(posedge clk_sys);
    chk("rate", 32'((convs - c0) >= 19 && (convs - c0) <= 21), 32'h1);
    end_sim();
  end

  initial
  begin
    repeat (100000) @(posedge clk_sys);
    bad_count++;
    end_sim();
  end
endmodule : ai_trigger_acquisition_control_tb_top

bind acq_trigger_ctrl acq_trigger_ctrl_props acq_trigger_ctrl_props_inst (
  .clk_sys       (clk_sys),
  .rstn          (rstn),
  .s_axi_awvalid (s_axi_awvalid),
  .s_axi_awready (s_axi_awready),
  .s_axi_bvalid  (s_axi_bvalid),
  .s_axi_bready  (s_axi_bready),
  .s_axi_bresp   (s_axi_bresp),
  .s_axi_arvalid (s_axi_arvalid),
  .s_axi_arready (s_axi_arready),
  .s_axi_rvalid  (s_axi_rvalid),
  .s_axi_rready  (s_axi_rready),
  .s_axi_rdata   (s_axi_rdata),
  .s_axi_rresp   (s_axi_rresp),
  .conv_start    (conv_start),
  .acq_active    (acq_active),
  .gain_sel      (gain_sel)
);
`default_nettype wire
